// ==== vrc_pkg.sv ====
package vrc_pkg;
   // geometry
   localparam int ROW_W = 9;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int ROW_COUNT = 512;
   // software port offsets
   localparam logic [3:0] OFF_CMD = 4'h0;
   localparam logic [3:0] OFF_ADDR = 4'h1;
   localparam logic [3:0] OFF_WDATA = 4'h2;
   localparam logic [3:0] OFF_STATUS = 4'h3;
   localparam logic [3:0] OFF_RDATA = 4'h4;
   localparam logic [3:0] OFF_CTRL = 4'h5;
   // command codes
   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_ROW_REFRESH = 3'h2;
   localparam logic [2:0] CMD_CBR = 3'h3;
   localparam logic [2:0] CMD_CBR_KEEP = 3'h4;
   localparam logic [2:0] CMD_CBR_STOP = 3'h5;
   localparam logic [2:0] CMD_MASK_LOAD = 3'h6;
   localparam logic [2:0] CMD_COLOR_LOAD = 3'h7;
   // ctrl field positions and reset
   localparam int CTRL_AUTO_REF_BIT = 0;
   localparam int CTRL_STOP_MODE_BIT = 1;
   localparam int CTRL_RETRACE_CBR_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int POWERUP_US = 100;
   localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
   localparam int INIT_CBR_COUNT = 8;
   localparam int REFRESH_WINDOW_MS = 32;
   // rows per window; interval rounded down so rate is met
   localparam int REFRESH_CYC = (REFRESH_WINDOW_MS * 1000 * CLK_MHZ) / ROW_COUNT;
   localparam int PHASE_NS = 30;
   localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam int STOP_ADDR_MAX = 127;

   typedef struct packed {
      logic row_enable_n;
      logic lower_byte_column_strobe_n;
      logic upper_byte_column_strobe_n;
      logic lower_store_strobe_n;
      logic upper_store_strobe_n;
      logic output_gate_n;
      logic special_function_select;
   } vrc_strobes_t;
endpackage

// ==== vrc_ctrl.sv ====
// Operation
// - wait 100us, then eight column-first refreshes
// - 512 refreshes every 32 ms
// - row-only refresh: row enable only, column high
// - column-first, select low: counter row refresh
// - half-depth emulation uses stop address at most 127; stop refreshes here drive no stop address, addr_pins keep their last value
// - one column-first refresh after each retrace
// - reissue stop refresh after column-first; else keep-modes
// - read: row, column, gate low, store high
// - split write transfer waits after last bit; this controller issues no transfer cycles
`timescale 1ns/1ps
module vrc_ctrl #(
   parameter int POWERUP_CYCLES = vrc_pkg::POWERUP_CYC,
   parameter int REFRESH_CYCLES = vrc_pkg::REFRESH_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   // software port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // display timing
   input wire logic vretrace,
   // device pins
   output vrc_pkg::vrc_strobes_t strobes,
   output logic [8:0] addr_pins,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic dq_oe_n
);
   typedef enum {ST_POWERUP, ST_IDLE, ST_PRE, ST_PH1, ST_PH2, ST_PH3, ST_DONE} vrc_state_t;
   vrc_state_t state_q;
   logic [2:0] op_q;
   logic [1:0] lanes_q;
   logic [17:0] addr_q;
   logic [15:0] wdata_q, rdata_q;
   logic [2:0] ctrl_q;
   logic busy_q, init_done_q, cmd_pend_q, auto_q, stop_req_q, retrace_d1_q, retrace_pend_q;
   logic [3:0] init_cnt_q;
   logic [16:0] wait_q;
   logic [23:0] ref_tmr_q;
   logic [3:0] ph_q;
   logic [31:0] sw_rdata_q;
   vrc_pkg::vrc_strobes_t pins_q;
   logic [8:0] apin_q;
   logic [15:0] dqo_q;
   logic dqoe_n_q;

   wire wr_cmd = sw_wr && sw_addr == vrc_pkg::OFF_CMD;
   wire ref_due = ref_tmr_q >= 24'(REFRESH_CYCLES - 1);
   wire retrace_rise = vretrace && !retrace_d1_q;
   wire ph_done = ph_q == 4'(vrc_pkg::PHASE_CYC - 1);
   wire is_cbr_kind = op_q == vrc_pkg::CMD_CBR || op_q == vrc_pkg::CMD_CBR_KEEP || op_q == vrc_pkg::CMD_CBR_STOP;
   wire is_wr_kind = op_q == vrc_pkg::CMD_WRITE || op_q == vrc_pkg::CMD_MASK_LOAD || op_q == vrc_pkg::CMD_COLOR_LOAD;
   wire is_special = op_q == vrc_pkg::CMD_MASK_LOAD || op_q == vrc_pkg::CMD_COLOR_LOAD;
   wire [2:0] auto_op = retrace_pend_q ? vrc_pkg::CMD_CBR :
                        stop_req_q ? vrc_pkg::CMD_CBR_STOP :
                        vrc_pkg::CMD_CBR_KEEP;
   wire start_auto = init_done_q && (ref_due || stop_req_q || retrace_pend_q) && ctrl_q[vrc_pkg::CTRL_AUTO_REF_BIT];
   wire [31:0] status_w = {27'h0, init_done_q, cmd_pend_q, busy_q, init_cnt_q == 4'h0, 1'b0};
   wire [31:0] rd_mux = sw_addr == vrc_pkg::OFF_STATUS ? status_w :
                        sw_addr == vrc_pkg::OFF_RDATA ? {16'h0, rdata_q} :
                        sw_addr == vrc_pkg::OFF_CTRL ? {29'h0, ctrl_q} :
                        sw_addr == vrc_pkg::OFF_ADDR ? {14'h0, addr_q} : 32'h0;

   assign sw_rdata = sw_rdata_q;
   assign strobes = pins_q;
   assign addr_pins = apin_q;
   assign dq_out = dqo_q;
   assign dq_oe_n = dqoe_n_q;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         sw_rdata_q <= 32'h0;
         ctrl_q <= vrc_pkg::CTRL_RESET;
         addr_q <= 18'h0;
         wdata_q <= 16'h0;
      end else if (clk_en) begin
         sw_rdata_q <= sw_rd ? rd_mux : 32'h0;
         if (sw_wr && sw_addr == vrc_pkg::OFF_CTRL) ctrl_q <= sw_wdata[2:0];
         if (sw_wr && sw_addr == vrc_pkg::OFF_ADDR) addr_q <= sw_wdata[17:0];
         if (sw_wr && sw_addr == vrc_pkg::OFF_WDATA) wdata_q <= sw_wdata[15:0];
      end
   end

   // pending software command, held until the sequencer is idle and starts no auto refresh
   logic [2:0] pend_op_q;
   logic [1:0] pend_lanes_q;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cmd_pend_q <= 1'b0;
         pend_op_q <= 3'h0;
         pend_lanes_q <= 2'h0;
         retrace_d1_q <= 1'b0;
         retrace_pend_q <= 1'b0;
         ref_tmr_q <= 24'h0;
      end else if (clk_en) begin
         retrace_d1_q <= vretrace;
         if (wr_cmd && !cmd_pend_q) begin
            cmd_pend_q <= 1'b1;
            pend_op_q <= sw_wdata[2:0];
            pend_lanes_q <= sw_wdata[5:4];
         end else if (state_q == ST_IDLE && !start_auto && cmd_pend_q) begin
            cmd_pend_q <= 1'b0;
         end
         // set wins over clear
         if (retrace_rise && ctrl_q[vrc_pkg::CTRL_RETRACE_CBR_BIT]) retrace_pend_q <= 1'b1;
         else if (state_q == ST_IDLE && start_auto && auto_op == vrc_pkg::CMD_CBR) retrace_pend_q <= 1'b0;
         if (state_q == ST_IDLE && start_auto) ref_tmr_q <= 24'h0;
         else if (!ref_due) ref_tmr_q <= ref_tmr_q + 24'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_q <= ST_POWERUP;
         wait_q <= 17'h0;
         init_cnt_q <= 4'(vrc_pkg::INIT_CBR_COUNT);
         init_done_q <= 1'b0;
         busy_q <= 1'b1;
         stop_req_q <= 1'b0;
         op_q <= vrc_pkg::CMD_CBR;
         lanes_q <= 2'h0;
         ph_q <= 4'h0;
         rdata_q <= 16'h0;
         pins_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
         apin_q <= 9'h0;
         dqo_q <= 16'h0;
         dqoe_n_q <= 1'b1;
      end else if (clk_en) begin
         ph_q <= ph_done ? 4'h0 : ph_q + 4'h1;
         case (state_q)
            ST_POWERUP: begin
               if (wait_q == 17'(POWERUP_CYCLES - 1)) state_q <= ST_IDLE;
               else wait_q <= wait_q + 17'h1;
            end
            ST_IDLE: begin
               ph_q <= 4'h0;
               busy_q <= 1'b0;
               if (!init_done_q) begin
                  op_q <= vrc_pkg::CMD_CBR;
                  state_q <= ST_PRE;
                  busy_q <= 1'b1;
               end else if (start_auto) begin
                  op_q <= auto_op;
                  lanes_q <= 2'h3;
                  state_q <= ST_PRE;
                  busy_q <= 1'b1;
               end else if (cmd_pend_q) begin
                  op_q <= pend_op_q;
                  lanes_q <= pend_lanes_q;
                  state_q <= ST_PRE;
                  busy_q <= 1'b1;
               end
            end
            ST_PRE: begin
               if (is_cbr_kind) begin
                  pins_q.lower_byte_column_strobe_n <= 1'b0;
                  pins_q.upper_byte_column_strobe_n <= 1'b0;
                  pins_q.lower_store_strobe_n <= op_q != vrc_pkg::CMD_CBR_STOP;
                  pins_q.upper_store_strobe_n <= op_q != vrc_pkg::CMD_CBR_STOP;
                  pins_q.special_function_select <= op_q != vrc_pkg::CMD_CBR;
               end else begin
                  apin_q <= addr_q[17:9];
                  pins_q.special_function_select <= is_special;
                  // early write: store strobes low before row falls selects lanes
                  pins_q.lower_store_strobe_n <= !(is_wr_kind && lanes_q[0]);
                  pins_q.upper_store_strobe_n <= !(is_wr_kind && lanes_q[1]);
               end
               if (ph_done) state_q <= ST_PH1;
            end
            ST_PH1: begin
               pins_q.row_enable_n <= 1'b0;
               if (ph_done) state_q <= ST_PH2;
            end
            ST_PH2: begin
               pins_q.special_function_select <= 1'b0;
               if (!is_cbr_kind && op_q != vrc_pkg::CMD_ROW_REFRESH) begin
                  apin_q <= addr_q[8:0];
                  pins_q.lower_byte_column_strobe_n <= !lanes_q[0];
                  pins_q.upper_byte_column_strobe_n <= !lanes_q[1];
                  if (op_q == vrc_pkg::CMD_READ) pins_q.output_gate_n <= 1'b0;
                  if (is_wr_kind) begin
                     dqo_q <= wdata_q;
                     dqoe_n_q <= 1'b0;
                  end
               end
               if (ph_done) state_q <= ST_PH3;
            end
            ST_PH3: begin
               // sample after access time, before gate releases
               if (ph_done) begin
                  if (op_q == vrc_pkg::CMD_READ) rdata_q <= dq_in;
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               // release all strobes, the gate and the data drivers together in the same cycle
               // full release phase gives recovery before any following cycle
               pins_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
               dqoe_n_q <= 1'b1;
               if (ph_done) begin
                  state_q <= ST_IDLE;
                  if (!init_done_q) begin
                     init_cnt_q <= init_cnt_q - 4'h1;
                     if (init_cnt_q == 4'h1) init_done_q <= 1'b1;
                  end
                  // a plain column-first wipes stop mode; restore it
                  if (op_q == vrc_pkg::CMD_CBR) stop_req_q <= ctrl_q[vrc_pkg::CTRL_STOP_MODE_BIT];
                  else if (op_q == vrc_pkg::CMD_CBR_STOP) stop_req_q <= 1'b0;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== vrc_props.sv ====
`timescale 1ns/1ps
module vrc_props #(
   parameter int POWERUP_CYCLES = 20,
   parameter int REFRESH_CYCLES = 200
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // device pins
   input wire vrc_pkg::vrc_strobes_t strobes,
   input wire logic dq_oe_n
);
   logic [15:0] up_q, gap_q;
   logic [3:0] nref_q;
   logic row_q;
   wire fall_w = row_q & ~strobes.row_enable_n;
   // gap restarts only on counter refreshes, so plain accesses cannot hide a missed refresh
   always_ff @(posedge clock) begin
      row_q <= strobes.row_enable_n;
      up_q <= !rstn ? 16'h0 : up_q + {15'h0, up_q != 16'hFFFF};
      gap_q <= (!rstn || (fall_w && !strobes.lower_byte_column_strobe_n)) ? 16'h0 : gap_q + 16'h1;
      nref_q <= !rstn ? 4'h0 : nref_q + {3'h0, fall_w && nref_q != 4'hF};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_cf; $fell(strobes.row_enable_n) ##0 !strobes.lower_byte_column_strobe_n; endsequence
   sequence s_held; !strobes.row_enable_n [*3]; endsequence
   sequence s_wr; $fell(strobes.lower_byte_column_strobe_n) ##0 !strobes.row_enable_n && !strobes.lower_store_strobe_n; endsequence
   a_powerup_quiet: assert property (up_q < POWERUP_CYCLES |-> strobes.row_enable_n)
      else $error("row active in power-up wait");
   a_init_col_first: assert property ($fell(strobes.row_enable_n) && nref_q < 4'h8 |-> s_cf)
      else $error("init refresh not column-first");
   a_refresh_gap: assert property (gap_q < REFRESH_CYCLES + 100)
      else $error("refresh overdue");
   a_row_stands: assert property ($fell(strobes.row_enable_n) |-> s_held)
      else $error("row phase too short");
   a_cbr_quiet: assert property (s_cf |-> dq_oe_n [*4])
      else $error("data driven in refresh");
   a_col_leads: assert property (s_cf |-> !$past(strobes.lower_byte_column_strobe_n))
      else $error("column strobe not ahead of row");
   a_gate_hiz: assert property (!strobes.output_gate_n |-> dq_oe_n)
      else $error("data driven while gate low");
   a_read_store: assert property (!strobes.output_gate_n |-> strobes.lower_store_strobe_n && strobes.upper_store_strobe_n)
      else $error("store low in read");
   a_write_drives: assert property (s_wr |-> !dq_oe_n)
      else $error("write data not driven at column strobe");
endmodule
bind vrc_ctrl vrc_props #(.POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES)) i_props (
   .clock(clock), .rstn(rstn), .strobes(strobes), .dq_oe_n(dq_oe_n));

// ==== vrc_dev_model.sv ====
`timescale 1ns/1ps
module vrc_dev_model (
   // controller pins
   input wire vrc_pkg::vrc_strobes_t strobes,
   input wire logic [8:0] addr_pins,
   input wire logic [15:0] dq_out,
   // device side
   output logic [15:0] dq_in,
   output logic stop_mode
);
   logic [15:0] mem [bit [17:0]];
   vrc_pkg::vrc_strobes_t p = '1;
   logic [8:0] row = 9'h0, col = 9'h0, ref_row = 9'h0;
   logic column_first_refresh = 1'b0, sf = 1'b0;
   // power-up leaves the default split boundary, no stop mode
   logic mode_q = 1'b0;
   logic [15:0] rd_q = 16'h0;
   assign stop_mode = mode_q;
   assign dq_in = rd_q;
   // released lanes show the inverse of their last value, never a held copy
   always @(strobes or dq_out) begin
      // address and data land in the same step as the strobes; let them settle
      #1;
      if (p.row_enable_n && !strobes.row_enable_n) begin
         column_first_refresh = !strobes.lower_byte_column_strobe_n;
         sf = strobes.special_function_select;
         row = addr_pins;
         // only array rows count; the shift buffer needs none
         ref_row = ref_row + {8'h0, column_first_refresh};
         if (column_first_refresh && !sf) mode_q = 1'b0;
         if (column_first_refresh && sf && !strobes.lower_store_strobe_n) mode_q = 1'b1;
      end
      if ((p[5] && !strobes[5]) || (p[4] && !strobes[4])) col = addr_pins;
      for (int i = 0; i < 2; i++) begin
         if (!column_first_refresh && !sf && !strobes[6] && !strobes[5-i] && !strobes[3-i] && (p[5-i] || p[3-i]))
            mem[{row, col}][8*i +: 8] = dq_out[8*i +: 8];
         if (!column_first_refresh && !strobes[6] && !strobes[5-i] && !strobes[1] && strobes[3-i] && mem.exists({row, col}))
            rd_q[8*i +: 8] = mem[{row, col}][8*i +: 8];
         else
            rd_q[8*i +: 8] = ~rd_q[8*i +: 8];
      end
      p = strobes;
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0, rstn = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, vretrace = 1'b0, dq_oe_n, stop_mode;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, rd, seed = 32'h851A;
   logic [15:0] dq_in, dq_out, wd [6];
   logic [8:0] addr_pins;
   logic [17:0] ad [6];
   vrc_pkg::vrc_strobes_t strobes;
   int err_count = 0, tests_run = 0;
   logic [2:0] mops [7] = '{vrc_pkg::CMD_CBR_STOP, vrc_pkg::CMD_ROW_REFRESH, vrc_pkg::CMD_CBR_KEEP,
      vrc_pkg::CMD_MASK_LOAD, vrc_pkg::CMD_COLOR_LOAD, vrc_pkg::CMD_CBR, vrc_pkg::CMD_CBR};
   logic [6:0] mexp = 7'h5F;
   always #5 clock = ~clock;
   vrc_ctrl #(.POWERUP_CYCLES(20), .REFRESH_CYCLES(200)) i_dut (.clock(clock), .rstn(rstn), .clk_en(1'b1),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .vretrace(vretrace), .strobes(strobes), .addr_pins(addr_pins), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n));
   vrc_dev_model i_dev (.strobes(strobes), .addr_pins(addr_pins), .dq_out(dq_out), .dq_in(dq_in),
      .stop_mode(stop_mode));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [31:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] ln);
      return {16'h0, ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
   endfunction
   task automatic test_done();
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= w;
      sw_rd <= !w;
      @(posedge clock);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      #1 rd = sw_rdata;
   endtask
   // ends with the read word in rd; a stuck command ends the run
   task automatic access(input logic [2:0] c, input logic [1:0] ln, input logic [17:0] a, input logic [15:0] d);
      bus(1'b1, vrc_pkg::OFF_ADDR, {14'h0, a});
      bus(1'b1, vrc_pkg::OFF_WDATA, {16'h0, d});
      bus(1'b1, vrc_pkg::OFF_CMD, {26'h0, ln, 1'b0, c});
      for (int n = 0; n < 60; n++) begin
         bus(1'b0, vrc_pkg::OFF_STATUS, 32'h0);
         if (rd[3:2] === 2'b00) begin
            bus(1'b0, vrc_pkg::OFF_RDATA, 32'h0);
            return;
         end
      end
      check(rd, 32'h0);
      test_done();
   endtask
   task automatic wait_stop(input logic e);
      for (int n = 0; n < 60 && stop_mode !== e; n++) begin
         @(posedge clock);
      end
      check({31'h0, stop_mode}, {31'h0, e});
      if (stop_mode !== e) test_done();
   endtask
   initial begin
      repeat (3) @(posedge clock);
      check({30'h0, dq_oe_n, strobes.row_enable_n}, 32'h3);
      rstn <= 1'b1;
      for (int n = 0; n < 300 && rd[4] !== 1'b1; n++) begin
         bus(1'b0, vrc_pkg::OFF_STATUS, 32'h0);
      end
      check({31'h0, rd[4]}, 32'h1);
      if (rd[4] !== 1'b1) test_done();
      bus(1'b0, vrc_pkg::OFF_CTRL, 32'h0);
      check(rd, {29'h0, vrc_pkg::CTRL_RESET});
      bus(1'b0, 4'hF, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         ad[i] = i == 0 ? 18'h3FFFF : i == 1 ? 18'h0 : seed[17:0];
         wd[i] = seed[31:16];
         access(vrc_pkg::CMD_WRITE, 2'b11, ad[i], wd[i]);
      end
      for (int i = 0; i < 6; i++) begin
         access(vrc_pkg::CMD_READ, 2'b11, ad[i], 16'h0);
         check(rd, {16'h0, wd[i]});
      end
      for (int i = 1; i < 3; i++) begin
         access(vrc_pkg::CMD_WRITE, 2'(i), ad[i+1], ~wd[i+1]);
         access(vrc_pkg::CMD_READ, 2'b11, ad[i+1], 16'h0);
         check(rd, merge(wd[i+1], ~wd[i+1], 2'(i)));
      end
      for (int i = 0; i < 7; i++) begin
         if (i == 6) begin
            bus(1'b1, vrc_pkg::OFF_CTRL, 32'h3);
         end
         access(mops[i], 2'b11, ad[0], 16'h0);
         wait_stop(mexp[i]);
      end
      bus(1'b1, vrc_pkg::OFF_CTRL, 32'h5);
      access(vrc_pkg::CMD_CBR_STOP, 2'b11, ad[0], 16'h0);
      wait_stop(1'b1);
      @(posedge clock);
      vretrace <= 1'b1;
      wait_stop(1'b0);
      test_done();
   end
endmodule
